// ===== lvd_top.sv
// Control, flag and wake logic of the low supply detector.
// Assumes an analog comparator and reference outside, driven by the
// power and tap outputs, and a core that samples the wake and vector lines.
`timescale 1ns/100ps
module lvd_top (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [lvd_pkg::ADDR_W-1:0] addr_i,
	input wire logic [lvd_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [lvd_pkg::DATA_W-1:0] rdata_o,
	input wire logic cmp_below_i,
	input wire logic ref_stable_i,
	input wire logic sleep_i,
	output logic detector_power_o,
	output logic [3:0] tap_select_o,
	output logic use_external_o,
	output logic irq_o,
	output logic wake_o,
	output logic irq_vector_o
);
	typedef struct packed {
		logic [3:0] level;
		logic power_en;
		logic global_irq_enable;
		lvd_pkg::lvd_state_e state;
		logic [7:0] rdata;
	} lvd_top_s;

	lvd_top_s s;
	lvd_top_s next_s;

	logic [lvd_pkg::SYNC_W-1:0] async_in;
	logic [lvd_pkg::SYNC_W-1:0] synced;
	logic cmp_sync;
	logic ref_sync;
	logic [lvd_pkg::EV_W-1:0] events;
	logic [lvd_pkg::EV_W-1:0] clears;
	logic [lvd_pkg::EV_W-1:0] status;
	logic [lvd_pkg::EV_W-1:0] mask;
	logic mask_we;
	logic pending;

	// Image of the control register as software sees it.
	function automatic logic [7:0] ctrl_image(input logic [3:0] level,
		input logic power_en, input logic ready);
		logic [7:0] img;
		img = lvd_pkg::READ_ZERO;
		img[lvd_pkg::CTRL_LEVEL_LSB +: lvd_pkg::CTRL_LEVEL_W] = level;
		img[lvd_pkg::CTRL_EN_BIT] = power_en;
		img[lvd_pkg::CTRL_RDY_BIT] = ready;
		return img;
	endfunction

	function automatic logic hit(input logic strobe, input logic [3:0] addr,
		input logic [3:0] target);
		return strobe && (addr == target);
	endfunction

	// The comparator and reference lines are analog and free-running.
	assign async_in[lvd_pkg::SYNC_CMP_BIT] = cmp_below_i;
	assign async_in[lvd_pkg::SYNC_REF_BIT] = ref_stable_i;

	lvd_sync #(
		.WIDTH(lvd_pkg::SYNC_W)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(async_in),
		.sync_o(synced)
	);

	assign cmp_sync = synced[lvd_pkg::SYNC_CMP_BIT];
	assign ref_sync = synced[lvd_pkg::SYNC_REF_BIT];

	always_comb begin
		next_s = s;
		if (hit(wr_i, addr_i, lvd_pkg::ADDR_CTRL)) begin
			// Code zero is passed on as is; the analog side leaves it undefined.
			next_s.level = wdata_i[lvd_pkg::CTRL_LEVEL_LSB +: lvd_pkg::CTRL_LEVEL_W];
			next_s.power_en = wdata_i[lvd_pkg::CTRL_EN_BIT];
		end
		if (hit(wr_i, addr_i, lvd_pkg::ADDR_CORE)) begin
			next_s.global_irq_enable = wdata_i[lvd_pkg::CORE_GIE_BIT];
		end
		// The wait for the reference is set by the analog side alone, so no
		// cycle count is kept here; the clock rate then does not matter.
		case (s.state)
			lvd_pkg::LVD_OFF: begin
				if (s.power_en) begin
					next_s.state = lvd_pkg::LVD_SETTLE;
				end
			end
			lvd_pkg::LVD_SETTLE: begin
				if (!s.power_en) begin
					next_s.state = lvd_pkg::LVD_OFF;
				end else if (ref_sync) begin
					next_s.state = lvd_pkg::LVD_ARMED;
				end
			end
			lvd_pkg::LVD_ARMED: begin
				if (!s.power_en) begin
					next_s.state = lvd_pkg::LVD_OFF;
				end else if (!ref_sync) begin
					next_s.state = lvd_pkg::LVD_SETTLE;
				end
			end
			default: begin
				next_s.state = lvd_pkg::LVD_OFF;
			end
		endcase
		next_s.rdata = lvd_pkg::READ_ZERO;
		if (rd_i) begin
			case (addr_i)
				lvd_pkg::ADDR_CTRL: begin
					next_s.rdata = ctrl_image(s.level, s.power_en,
						s.state == lvd_pkg::LVD_ARMED);
				end
				lvd_pkg::ADDR_STATUS: begin
					next_s.rdata[lvd_pkg::EV_W-1:0] = status;
				end
				lvd_pkg::ADDR_MASK: begin
					next_s.rdata[lvd_pkg::EV_W-1:0] = mask;
				end
				lvd_pkg::ADDR_CORE: begin
					next_s.rdata[lvd_pkg::CORE_GIE_BIT] = s.global_irq_enable;
				end
				default: begin
					next_s.rdata = lvd_pkg::READ_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s.level <= lvd_pkg::LEVEL_RESET;
			s.power_en <= 1'b0;
			s.global_irq_enable <= 1'b0;
			s.state <= lvd_pkg::LVD_OFF;
			s.rdata <= lvd_pkg::READ_ZERO;
		end else begin
			s <= next_s;
		end
	end

	// Flag raised only while armed, so a false trip while the
	// reference settles never reaches software.
	// Power enable gates the flag too: a write that powers down leaves the state
	// armed for one cycle, and a trip seen then must not reach software.
	assign events[lvd_pkg::EV_FLAG_BIT] = (s.state == lvd_pkg::LVD_ARMED) && s.power_en &&
		cmp_sync;
	assign events[lvd_pkg::EV_STABLE_BIT] = (s.state == lvd_pkg::LVD_SETTLE) &&
		s.power_en && ref_sync;
	assign clears = hit(wr_i, addr_i, lvd_pkg::ADDR_STATUS) ?
		wdata_i[lvd_pkg::EV_W-1:0] : '0;
	assign mask_we = hit(wr_i, addr_i, lvd_pkg::ADDR_MASK);

	lvd_irq #(
		.EV_W(lvd_pkg::EV_W)
	) u_irq (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.event_i(events),
		.clear_i(clears),
		.mask_we_i(mask_we),
		.mask_wdata_i(wdata_i[lvd_pkg::EV_W-1:0]),
		.status_o(status),
		.mask_o(mask),
		.irq_o(pending)
	);

	assign rdata_o = s.rdata;
	assign detector_power_o = s.power_en;
	assign tap_select_o = s.level;
	assign use_external_o = (s.level == lvd_pkg::LEVEL_EXTERNAL);
	assign irq_o = pending;
	// Wake needs no global enable; the core decides where to resume.
	assign wake_o = sleep_i && pending;
	assign irq_vector_o = pending && s.global_irq_enable;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence ctrl_write;
		hit(wr_i, addr_i, lvd_pkg::ADDR_CTRL);
	endsequence

	sequence ctrl_read;
		hit(rd_i, addr_i, lvd_pkg::ADDR_CTRL);
	endsequence

	sequence powered_up;
		$rose(s.power_en);
	endsequence

	sequence ref_absent;
		!ref_sync [*3];
	endsequence

	sequence quiet_regs;
		!hit(wr_i, addr_i, lvd_pkg::ADDR_MASK) && !hit(wr_i, addr_i, lvd_pkg::ADDR_CORE) &&
			!hit(wr_i, addr_i, lvd_pkg::ADDR_STATUS);
	endsequence

	sequence flag_unmasked;
		events[lvd_pkg::EV_FLAG_BIT] && mask[lvd_pkg::EV_FLAG_BIT];
	endsequence

	sequence status_write;
		hit(wr_i, addr_i, lvd_pkg::ADDR_STATUS);
	endsequence

	sequence mask_write;
		hit(wr_i, addr_i, lvd_pkg::ADDR_MASK);
	endsequence

	sequence core_write;
		hit(wr_i, addr_i, lvd_pkg::ADDR_CORE);
	endsequence

	sequence settling;
		s.state == lvd_pkg::LVD_SETTLE && s.power_en;
	endsequence

	sequence armed_state;
		s.state == lvd_pkg::LVD_ARMED;
	endsequence

	level_write_a: assert property (ctrl_write |=>
		tap_select_o == $past(wdata_i[3:0]))
		else $error("Trip level did not follow the write.");
	external_sel_a: assert property (ctrl_write ##0 (wdata_i[3:0] == 4'hf) |=>
		use_external_o)
		else $error("External input not selected for level all ones.");
	tap_code_a: assert property (ctrl_write ##0 (wdata_i[3:0] != 4'hf) |=>
		!use_external_o && tap_select_o == $past(wdata_i[3:0]))
		else $error("Divider tap code was altered.");
	power_write_a: assert property (ctrl_write |=>
		detector_power_o == $past(wdata_i[4]))
		else $error("Power enable did not follow the write.");
	ready_read_a: assert property (ctrl_read |=>
		rdata_o[5] == $past(s.state == lvd_pkg::LVD_ARMED))
		else $error("Reference stable bit read wrong.");
	top_zero_a: assert property (ctrl_read |=> rdata_o[7:6] == 2'h0)
		else $error("Unused control bits read nonzero.");
	flag_gate_a: assert property (events[lvd_pkg::EV_FLAG_BIT] |->
		s.power_en && $past(ref_stable_i, 3))
		else $error("Flag raised before the reference settled.");
	analog_wait_a: assert property (powered_up ##0 ref_absent |->
		s.state != lvd_pkg::LVD_ARMED)
		else $error("Detector armed without a stable reference.");
	flag_source_a: assert property (events[lvd_pkg::EV_FLAG_BIT] |->
		$past(cmp_below_i, 2))
		else $error("Flag raised without a synchronised trip.");
	sleep_wake_a: assert property (flag_unmasked ##0 quiet_regs ##1 sleep_i |->
		wake_o)
		else $error("Trip in sleep did not wake the core.");
	vector_gie_a: assert property (flag_unmasked ##0 quiet_regs ##0 s.global_irq_enable |=>
		irq_vector_o)
		else $error("Vector not taken with global enable set.");
	no_vector_a: assert property (!s.global_irq_enable |-> !irq_vector_o)
		else $error("Vector taken with global enable clear.");
	reset_state_a: assert property ($past(sys_rst_i) |->
		tap_select_o == 4'h5 && !detector_power_o)
		else $error("Control register reset value wrong.");
	flag_sticky_a: assert property (status[lvd_pkg::EV_FLAG_BIT] &&
		!clears[lvd_pkg::EV_FLAG_BIT] |=> status[lvd_pkg::EV_FLAG_BIT])
		else $error("Low supply flag dropped by itself.");
	idle_read_a: assert property (!rd_i |=> rdata_o == 8'h00)
		else $error("Read data not zero outside a read.");
	status_read_a: assert property (hit(rd_i, addr_i, lvd_pkg::ADDR_STATUS) |=>
		rdata_o == 8'($past(status)))
		else $error("Status register read wrong.");
	mask_read_a: assert property (hit(rd_i, addr_i, lvd_pkg::ADDR_MASK) |=>
		rdata_o == 8'($past(mask)))
		else $error("Mask register read wrong.");
	core_read_a: assert property (hit(rd_i, addr_i, lvd_pkg::ADDR_CORE) |=>
		rdata_o == 8'($past(s.global_irq_enable)))
		else $error("Global enable read wrong.");
	mask_write_a: assert property (mask_write |=>
		mask == $past(wdata_i[lvd_pkg::EV_W-1:0]))
		else $error("Mask did not follow the write.");
	core_write_a: assert property (core_write |=>
		s.global_irq_enable == $past(wdata_i[lvd_pkg::CORE_GIE_BIT]))
		else $error("Global enable did not follow the write.");
	clear_flag_a: assert property (status_write ##0 wdata_i[lvd_pkg::EV_FLAG_BIT] ##0
		!events[lvd_pkg::EV_FLAG_BIT] |=> !status[lvd_pkg::EV_FLAG_BIT])
		else $error("Flag survived a clear with no trip.");
	flag_set_a: assert property (events[lvd_pkg::EV_FLAG_BIT] |=>
		status[lvd_pkg::EV_FLAG_BIT])
		else $error("Trip did not set the flag.");
	irq_flag_a: assert property (status[lvd_pkg::EV_FLAG_BIT] &&
		mask[lvd_pkg::EV_FLAG_BIT] |-> irq_o)
		else $error("Unmasked flag raised no interrupt.");
	no_wake_a: assert property (!sleep_i |-> !wake_o)
		else $error("Wake raised while the core is awake.");
	no_flag_off_a: assert property (!s.power_en |->
		!events[lvd_pkg::EV_FLAG_BIT])
		else $error("Flag raised with the detector off.");
	ctrl_hold_a: assert property (!ctrl_write |=>
		$stable(tap_select_o) && $stable(detector_power_o))
		else $error("Control outputs changed without a write.");
	reset_regs_a: assert property ($past(sys_rst_i) |->
		status == '0 && mask == '0 && !s.global_irq_enable && s.state == lvd_pkg::LVD_OFF)
		else $error("Status, mask or state not cleared by reset.");
	settle_first_a: assert property (powered_up |=>
		s.state != lvd_pkg::LVD_ARMED)
		else $error("Detector armed in the cycle after power up.");
	armed_ref_a: assert property (armed_state |-> $past(ref_sync))
		else $error("Armed without a synchronised stable reference.");
	ready_drop_a: assert property (armed_state ##0 !ref_sync |=>
		s.state != lvd_pkg::LVD_ARMED)
		else $error("Stayed armed after the reference dropped.");
	power_off_a: assert property (!s.power_en |=>
		s.state == lvd_pkg::LVD_OFF)
		else $error("Detector stayed active after power down.");
	stable_event_a: assert property (settling ##0 ref_sync |=>
		s.state == lvd_pkg::LVD_ARMED && status[lvd_pkg::EV_STABLE_BIT])
		else $error("Stable reference did not arm the detector.");
	external_keep_a: assert property (use_external_o |->
		tap_select_o == lvd_pkg::LEVEL_EXTERNAL)
		else $error("External input selected for another level.");
endmodule

// ===== lvd_pkg.sv
// Constants, register map and state encoding for the low supply detector.
// Assumes an 8-bit register port with a 4-bit word address.
package lvd_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int EV_W = 2;
	localparam int SYNC_W = 2;

	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h2;
	localparam logic [3:0] ADDR_CORE = 4'h3;

	localparam int CTRL_LEVEL_LSB = 0;
	localparam int CTRL_LEVEL_W = 4;
	localparam int CTRL_EN_BIT = 4;
	localparam int CTRL_RDY_BIT = 5;
	localparam int CORE_GIE_BIT = 0;

	localparam int EV_FLAG_BIT = 0;
	localparam int EV_STABLE_BIT = 1;

	localparam int SYNC_CMP_BIT = 0;
	localparam int SYNC_REF_BIT = 1;

	localparam logic [3:0] LEVEL_RESET = 4'h5;
	localparam logic [3:0] LEVEL_EXTERNAL = 4'hf;
	localparam logic [3:0] LEVEL_RESERVED = 4'h0;
	localparam logic [1:0] EV_MASK_RESET = 2'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;

	typedef enum logic [1:0] {
		LVD_OFF = 2'h0,
		LVD_SETTLE = 2'h1,
		LVD_ARMED = 2'h3
	} lvd_state_e;
endpackage

// ===== lvd_sync.sv
// Two-stage synchroniser for slow asynchronous levels.
// Assumes the inputs change far slower than the core clock.
`timescale 1ns/100ps
module lvd_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} lvd_sync_s;

	lvd_sync_s s;
	lvd_sync_s next_s;

	if (WIDTH < 1) begin : bad_width
		$error("Synchroniser width must be at least one.");
	end

	always_comb begin
		next_s.meta = async_i;
		next_s.stable = s.meta;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_o = s.stable;
endmodule

// ===== lvd_irq.sv
// Sticky event status with write-one-to-clear and a matching mask.
// Assumes clear and mask strobes are already decoded by the owner.
`timescale 1ns/100ps
module lvd_irq #(
	parameter int EV_W = 2
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [EV_W-1:0] event_i,
	input wire logic [EV_W-1:0] clear_i,
	input wire logic mask_we_i,
	input wire logic [EV_W-1:0] mask_wdata_i,
	output logic [EV_W-1:0] status_o,
	output logic [EV_W-1:0] mask_o,
	output logic irq_o
);
	typedef struct packed {
		logic [EV_W-1:0] status;
		logic [EV_W-1:0] mask;
	} lvd_irq_s;

	lvd_irq_s s;
	lvd_irq_s next_s;

	if (EV_W < 1) begin : bad_width
		$error("At least one event is needed.");
	end

	always_comb begin
		next_s = s;
		// A new event wins over a clear in the same cycle.
		next_s.status = (s.status & ~clear_i) | event_i;
		if (mask_we_i) begin
			next_s.mask = mask_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s.status <= '0;
			s.mask <= EV_W'(lvd_pkg::EV_MASK_RESET);
		end else begin
			s <= next_s;
		end
	end

	assign status_o = s.status;
	assign mask_o = s.mask;
	assign irq_o = |(s.status & s.mask);

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	set_beats_clear_a: assert property ((event_i & clear_i) != '0 |=>
		(status_o & $past(event_i & clear_i)) == $past(event_i & clear_i))
		else $error("An event was lost to a clear.");
	clear_works_a: assert property ((clear_i & status_o & ~event_i) != '0 |=>
		(status_o & $past(clear_i & ~event_i)) == '0)
		else $error("A status bit ignored its clear.");
endmodule

// ===== tb_top.sv
// Self-checking bench for the low supply detector control block.
// Assumes one 40 MHz clock, a one-cycle register port and slow analog inputs.
`timescale 1ns/100ps
module tb_top;
	logic clk, rst, wr, rd, cmp_below, ref_stable, sleep;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, rv;
	logic power, use_ext, irq, wake, vector;
	logic [3:0] tap;
	logic [31:0] seed;
	int errors, checks_done, cycles;

	lvd_top dut (.clk_i(clk), .sys_rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .cmp_below_i(cmp_below), .ref_stable_i(ref_stable),
		.sleep_i(sleep), .detector_power_o(power), .tap_select_o(tap),
		.use_external_o(use_ext), .irq_o(irq), .wake_o(wake), .irq_vector_o(vector));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// Expected control image: top bits never writable, ready bit from the analog side.
	function automatic logic [7:0] ctrl_image(input logic [7:0] w, input logic ready);
		return {2'h0, ready, w[4:0]};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Lets the edges land, then samples a little after the last one.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic set_analog(input logic c, input logic r, input logic s);
		@(posedge clk);
		cmp_below <= c;
		ref_stable <= r;
		sleep <= s;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end

	initial begin
		logic [7:0] w;
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		cmp_below = 1'b0;
		ref_stable = 1'b0;
		sleep = 1'b0;
		seed = 32'h0000_3601;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		tick(1);
		check({power, tap, use_ext, irq, wake}, 8'h28);
		check({7'h00, vector}, 8'h00);
		reg_read(4'h0, rv);
		check(rv, 8'h05);
		tick(1);
		check(rdata, 8'h00);
		// Every level code, with random upper bits to probe the read-only field.
		for (int i = 0; i < 16; i++) begin
			seed = xorshift(seed);
			w = {seed[7:4], i[3:0]};
			set_analog(seed[8], 1'b0, seed[9]);
			reg_write(4'h0, w);
			tick(1);
			check({3'h0, power, tap}, {3'h0, w[4], w[3:0]});
			check({7'h00, use_ext}, {7'h00, (w[3:0] == 4'hf)});
			reg_read(4'h0, rv);
			check(rv, ctrl_image(w, 1'b0));
		end
		reg_write(4'h2, 8'h00);
		reg_write(4'h1, 8'hff);
		// Trip present while the reference is still settling must be ignored.
		set_analog(1'b1, 1'b0, 1'b0);
		reg_write(4'h0, 8'h19);
		tick(8);
		reg_read(4'h1, rv);
		check(rv, 8'h00);
		set_analog(1'b1, 1'b1, 1'b0);
		tick(6);
		reg_read(4'h0, rv);
		check(rv, ctrl_image(8'h19, 1'b1));
		reg_read(4'h1, rv);
		check(rv, 8'h03);
		check({7'h00, irq}, 8'h00);
		set_analog(1'b0, 1'b1, 1'b0);
		tick(6);
		reg_read(4'h1, rv);
		check(rv, 8'h03);
		reg_write(4'h1, 8'h03);
		reg_read(4'h1, rv);
		check(rv, 8'h00);
		reg_write(4'h2, 8'h01);
		reg_write(4'h3, 8'h00);
		set_analog(1'b1, 1'b1, 1'b1);
		tick(6);
		check({5'h00, irq, wake, vector}, 8'h06);
		reg_write(4'h3, 8'h01);
		tick(1);
		check({5'h00, irq, wake, vector}, 8'h07);
		// A clear that meets a standing trip loses; the flag sets again at once.
		reg_write(4'h1, 8'h01);
		reg_read(4'h1, rv);
		check(rv, 8'h01);
		reg_read(4'h2, rv);
		check(rv, 8'h01);
		reg_read(4'h3, rv);
		check(rv, 8'h01);
		set_analog(1'b0, 1'b1, 1'b0);
		tick(4);
		check({5'h00, irq, wake, vector}, 8'h05);
		reg_write(4'h1, 8'h01);
		tick(1);
		check({5'h00, irq, wake, vector}, 8'h00);
		// Power down drops the ready bit and blocks new flags.
		reg_write(4'h0, 8'h0e);
		set_analog(1'b1, 1'b1, 1'b0);
		tick(6);
		reg_read(4'h0, rv);
		check(rv, 8'h0e);
		reg_read(4'h1, rv);
		check({7'h00, rv[0]}, 8'h00);
		reg_write(4'h9, 8'hff);
		reg_read(4'h9, rv);
		check(rv, 8'h00);
		reg_read(4'h0, rv);
		check(rv, 8'h0e);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		reg_read(4'h0, rv);
		check(rv, 8'h05);
		check({power, tap, use_ext, irq, wake}, 8'h28);
		reg_read(4'h1, rv);
		check(rv, 8'h00);
		stop_test();
	end
endmodule
